// file: core/asq_pkg.sv
// package: register map, field layout, timing and carrier types of the converter sequencer
package asq_pkg;
	localparam int ADDR_WIDTH = 8;
	localparam logic [7:0] OFFSET_CTRL0 = 8'h00;
	localparam logic [7:0] OFFSET_CTRL1 = 8'h04;
	localparam logic [7:0] OFFSET_CTRL2 = 8'h08;
	localparam logic [7:0] OFFSET_PIN_FUNC = 8'h0c;
	localparam logic [7:0] OFFSET_RESULT_HI = 8'h10;
	localparam logic [7:0] OFFSET_RESULT_LO = 8'h14;

	// conv_control_reg0
	localparam int CTRL0_START = 7;
	localparam int CTRL0_BUSY = 6;
	localparam int CTRL0_POWER = 5;
	localparam int CTRL0_ALIGN = 4;
	localparam int CTRL0_CHSEL_LO = 0;
	// conv_control_reg1
	localparam int CTRL1_SRC_LO = 4;
	localparam int CTRL1_DIV_LO = 0;
	// conv_control_reg2
	localparam int CTRL2_AMP_EN = 7;
	localparam int CTRL2_AMP_IS = 4;
	localparam int CTRL2_REF_LO = 2;
	localparam int CTRL2_GAIN_LO = 0;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] PIN_FUNC_RESET = 16'h0000;

	localparam logic [3:0] SAMPLE_TICKS = 4'h4;
	localparam logic [3:0] CONVERT_TICKS = 4'hc;
	localparam int RESULT_WIDTH = 12;
	localparam int NUM_CHANNELS = 12;

	typedef enum logic [2:0] {
		ASQ_IDLE = 3'b001,
		ASQ_SAMPLE = 3'b010,
		ASQ_CONVERT = 3'b100
	} asq_state_type;

	typedef struct packed {
		logic amp_power;
		logic [1:0] amp_gain;
		logic amp_from_pin;
		logic amp_from_bandgap;
		logic ref_supply;
		logic ref_ext_pin;
		logic ref_amp;
	} asq_ref_route_type;

	typedef struct packed {
		logic ext_path;
		logic supply_full;
		logic supply_half;
		logic supply_quarter;
		logic amp_full;
		logic amp_half;
		logic amp_quarter;
		logic ground;
	} asq_in_route_type;
endpackage : asq_pkg

// file: core/asq_top.sv
// converter sequencing, reference and input selection with an apb register file
`timescale 1ns/1ns
module asq_top #(
	parameter int NUM_CH = asq_pkg::NUM_CHANNELS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [asq_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [asq_pkg::RESULT_WIDTH-1:0] adc_data_in,
	output logic conv_power,
	output logic conv_clk_tick,
	output logic conv_sample,
	output logic conv_convert,
	output logic conv_done,
	output asq_pkg::asq_ref_route_type ref_route,
	output asq_pkg::asq_in_route_type in_route,
	output logic [NUM_CH-1:0] ext_channel_connect,
	input wire logic [NUM_CH-1:0] port_pullup_req,
	input wire logic [NUM_CH-1:0] port_out_enable_req,
	output logic [NUM_CH-1:0] pin_pullup_en,
	output logic [NUM_CH-1:0] pin_out_enable,
	output logic [NUM_CH-1:0] pin_digital_en
);
	logic start_bit;
	logic conv_busy_flag;
	logic converter_power_enable;
	logic result_align_sel;
	logic [3:0] ext_channel_sel;
	logic [3:0] input_source_sel;
	logic [2:0] conv_clock_div_sel;
	logic ref_amp_enable;
	logic ref_amp_input_sel;
	logic [1:0] ref_source_sel;
	logic [1:0] ref_amp_gain_sel;
	logic [NUM_CH-1:0] pin_analog_en;
	logic [7:0] result_hi;
	logic [7:0] result_lo;
	logic [asq_pkg::RESULT_WIDTH-1:0] data_meta;
	logic [asq_pkg::RESULT_WIDTH-1:0] data_sync;
	asq_pkg::asq_state_type state;
	logic [6:0] div_cnt;
	logic [6:0] div_limit;
	logic tick;
	logic [3:0] tick_cnt;
	logic access;
	logic wr_en;
	logic wr_ctrl0;
	logic start_go;
	logic conv_last;
	logic ext_selected;
	logic mapped;
	logic [7:0] ctrl0_read;
	logic [7:0] ctrl1_read;
	logic [7:0] ctrl2_read;
	logic [31:0] read_word;

	// one wait state: pready rises in the second access cycle
	assign access = psel & penable;
	assign wr_en = access & pready & pwrite;
	assign wr_ctrl0 = wr_en & (paddr == asq_pkg::OFFSET_CTRL0);
	// high already stored, now written low: the low-high-low sequence ends here
	assign start_go = wr_ctrl0 & start_bit & ~pwdata[asq_pkg::CTRL0_START]
		& pwdata[asq_pkg::CTRL0_POWER];

	assign ctrl0_read = {start_bit, conv_busy_flag, converter_power_enable, result_align_sel,
		ext_channel_sel};
	assign ctrl1_read = {input_source_sel, 1'b0, conv_clock_div_sel};
	assign ctrl2_read = {ref_amp_enable, 2'b00, ref_amp_input_sel, ref_source_sel,
		ref_amp_gain_sel};

	always_comb begin
		mapped = 1'b1;
		read_word = 32'h0000_0000;
		unique case (paddr)
			asq_pkg::OFFSET_CTRL0: read_word[7:0] = ctrl0_read;
			asq_pkg::OFFSET_CTRL1: read_word[7:0] = ctrl1_read;
			asq_pkg::OFFSET_CTRL2: read_word[7:0] = ctrl2_read;
			asq_pkg::OFFSET_PIN_FUNC: read_word[NUM_CH-1:0] = pin_analog_en;
			asq_pkg::OFFSET_RESULT_HI: read_word[7:0] = result_hi;
			asq_pkg::OFFSET_RESULT_LO: read_word[7:0] = result_lo;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			prdata <= (access & ~pready & ~pwrite) ? read_word : 32'h0000_0000;
			pslverr <= access & ~pready & ~mapped;
		end
	end

	// software-owned control fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_bit <= 1'b0;
			converter_power_enable <= 1'b0;
			result_align_sel <= 1'b0;
			ext_channel_sel <= 4'h0;
			input_source_sel <= 4'h0;
			conv_clock_div_sel <= 3'h0;
			ref_amp_enable <= 1'b0;
			ref_amp_input_sel <= 1'b0;
			ref_source_sel <= 2'h0;
			ref_amp_gain_sel <= 2'h0;
			pin_analog_en <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				asq_pkg::OFFSET_CTRL0: begin
					start_bit <= pwdata[asq_pkg::CTRL0_START];
					converter_power_enable <= pwdata[asq_pkg::CTRL0_POWER];
					result_align_sel <= pwdata[asq_pkg::CTRL0_ALIGN];
					ext_channel_sel <= pwdata[asq_pkg::CTRL0_CHSEL_LO +: 4];
				end
				asq_pkg::OFFSET_CTRL1: begin
					input_source_sel <= pwdata[asq_pkg::CTRL1_SRC_LO +: 4];
					conv_clock_div_sel <= pwdata[asq_pkg::CTRL1_DIV_LO +: 3];
				end
				asq_pkg::OFFSET_CTRL2: begin
					ref_amp_enable <= pwdata[asq_pkg::CTRL2_AMP_EN];
					ref_amp_input_sel <= pwdata[asq_pkg::CTRL2_AMP_IS];
					ref_source_sel <= pwdata[asq_pkg::CTRL2_REF_LO +: 2];
					ref_amp_gain_sel <= pwdata[asq_pkg::CTRL2_GAIN_LO +: 2];
				end
				asq_pkg::OFFSET_PIN_FUNC: pin_analog_en <= pwdata[NUM_CH-1:0];
				default: ;
			endcase
		end
	end

	// conversion clock: one tick every 2**div_sel system clocks
	assign div_limit = 7'((8'h01 << conv_clock_div_sel) - 8'h01);
	assign tick = (div_cnt == div_limit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 7'h00;
		end else if (start_go || tick || state == asq_pkg::ASQ_IDLE) begin
			div_cnt <= 7'h00;
		end else begin
			div_cnt <= div_cnt + 7'h01;
		end
	end

	assign conv_last = (state == asq_pkg::ASQ_CONVERT) && tick
		&& (tick_cnt == asq_pkg::CONVERT_TICKS - 4'h1);

	// a fresh start restarts the sequence even mid-conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= asq_pkg::ASQ_IDLE;
			tick_cnt <= 4'h0;
		end else if (start_go) begin
			state <= asq_pkg::ASQ_SAMPLE;
			tick_cnt <= 4'h0;
		end else if (!converter_power_enable) begin
			state <= asq_pkg::ASQ_IDLE;
			tick_cnt <= 4'h0;
		end else if (tick) begin
			unique case (state)
				asq_pkg::ASQ_SAMPLE: begin
					if (tick_cnt == asq_pkg::SAMPLE_TICKS - 4'h1) begin
						state <= asq_pkg::ASQ_CONVERT;
						tick_cnt <= 4'h0;
					end else begin
						tick_cnt <= tick_cnt + 4'h1;
					end
				end
				asq_pkg::ASQ_CONVERT: begin
					if (conv_last) begin
						state <= asq_pkg::ASQ_IDLE;
						tick_cnt <= 4'h0;
					end else begin
						tick_cnt <= tick_cnt + 4'h1;
					end
				end
				asq_pkg::ASQ_IDLE: tick_cnt <= 4'h0;
			endcase
		end
	end

	// only start, completion and power-off move the flag; bus writes never reach it directly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_busy_flag <= 1'b0;
		end else if (start_go) begin
			conv_busy_flag <= 1'b1;
		end else if (conv_last || !converter_power_enable) begin
			conv_busy_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_done <= 1'b0;
			conv_clk_tick <= 1'b0;
			conv_sample <= 1'b0;
			conv_convert <= 1'b0;
			conv_power <= 1'b0;
		end else begin
			conv_done <= conv_last & ~start_go;
			conv_clk_tick <= tick & (state != asq_pkg::ASQ_IDLE);
			conv_sample <= (state == asq_pkg::ASQ_SAMPLE);
			conv_convert <= (state == asq_pkg::ASQ_CONVERT);
			conv_power <= converter_power_enable;
		end
	end

	// analog data crosses into pclk through two stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_meta <= '0;
			data_sync <= '0;
		end else begin
			data_meta <= adc_data_in;
			data_sync <= data_meta;
		end
	end

	// result holds while the converter is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_hi <= 8'h00;
			result_lo <= 8'h00;
		end else if (conv_last) begin
			if (result_align_sel) begin
				result_hi <= {4'h0, data_sync[11:8]};
				result_lo <= data_sync[7:0];
			end else begin
				result_hi <= data_sync[11:4];
				result_lo <= {data_sync[3:0], 4'h0};
			end
		end
	end

	// reference path and amplifier controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_route <= '0;
		end else begin
			ref_route.amp_power <= ref_amp_enable;
			ref_route.amp_gain <= ref_amp_gain_sel;
			ref_route.amp_from_pin <= ~ref_amp_input_sel;
			ref_route.amp_from_bandgap <= ref_amp_input_sel;
			ref_route.ref_supply <= (ref_source_sel == 2'b00);
			ref_route.ref_ext_pin <= (ref_source_sel == 2'b01);
			ref_route.ref_amp <= ref_source_sel[1];
		end
	end

	// one decode feeds both the input route and the channel switches
	assign ext_selected = (input_source_sel == 4'h0) || (input_source_sel == 4'h4)
		|| (input_source_sel[3:2] == 2'b11);

	// converter input selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_route <= '0;
		end else begin
			in_route.ext_path <= ext_selected;
			in_route.supply_full <= (input_source_sel == 4'h1);
			in_route.supply_half <= (input_source_sel == 4'h2);
			in_route.supply_quarter <= (input_source_sel == 4'h3);
			in_route.amp_full <= (input_source_sel == 4'h5);
			in_route.amp_half <= (input_source_sel == 4'h6);
			in_route.amp_quarter <= (input_source_sel == 4'h7);
			in_route.ground <= (input_source_sel[3:2] == 2'b10);
		end
	end

	// per-pin gating: channel switch and port overrides
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_pin
		// codes past the last channel match nothing and leave the input floating
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ext_channel_connect[ch] <= 1'b0;
			end else begin
				ext_channel_connect[ch] <= ext_selected && (ext_channel_sel == 4'(ch));
			end
		end
		// pull-high cut while analog, whatever the port logic asks
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pin_pullup_en[ch] <= 1'b0;
			end else begin
				pin_pullup_en[ch] <= port_pullup_req[ch] & ~pin_analog_en[ch];
			end
		end
		// direction override: software need not make the pin an input first
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pin_out_enable[ch] <= 1'b0;
			end else begin
				pin_out_enable[ch] <= port_out_enable_req[ch] & ~pin_analog_en[ch];
			end
		end
		// digital input and shared functions off while analog
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pin_digital_en[ch] <= 1'b1;
			end else begin
				pin_digital_en[ch] <= ~pin_analog_en[ch];
			end
		end
	end
endmodule : asq_top

// file: testbench/adc_sequencing_and_input_select_bench.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
`define CHK(n, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) begin \
			fail_count++; \
			$display("MISMATCH %s exp %h got %h", n, e, g); \
		end \
	end
module adc_sequencing_and_input_select_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, conv_power, conv_clk_tick, conv_sample, conv_convert, conv_done;
	logic [11:0] adc_data_in = 12'h000, ext_channel_connect, pin_pullup_en, pin_out_enable;
	logic [11:0] pin_digital_en, port_pullup_req = 12'hfff, port_out_enable_req = 12'hfff;
	asq_pkg::asq_ref_route_type ref_route;
	asq_pkg::asq_in_route_type in_route;
	int fail_count = 0, total_checks = 0, n_samp, n_conv, n_tick, n_done;
	asq_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_data_in(adc_data_in), .conv_power(conv_power),
		.conv_clk_tick(conv_clk_tick), .conv_sample(conv_sample), .conv_convert(conv_convert),
		.conv_done(conv_done), .ref_route(ref_route), .in_route(in_route),
		.ext_channel_connect(ext_channel_connect), .port_pullup_req(port_pullup_req),
		.port_out_enable_req(port_out_enable_req), .pin_pullup_en(pin_pullup_en),
		.pin_out_enable(pin_out_enable), .pin_digital_en(pin_digital_en));
	initial begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		n_samp += conv_sample;
		n_conv += conv_convert;
		n_tick += conv_clk_tick;
		n_done += conv_done;
	end
	// ends half a cycle after the registered outputs follow the write
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait-state count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		@(negedge pclk);
	endtask : apb
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic t_regs();
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			`CHK("rd", 32'h0, rd)
			`CHK("err", i == 6, err)
		end
		apb(1'b1, asq_pkg::OFFSET_CTRL0, 32'h40);
		apb(1'b0, asq_pkg::OFFSET_CTRL0, 32'h0);
		`CHK("busy", 32'h0, rd)
	endtask : t_regs
	task automatic t_route();
		logic [7:0] e;
		logic ext;
		for (int s = 0; s < 16; s++) begin
			apb(1'b1, asq_pkg::OFFSET_CTRL1, 32'(s << 4));
			ext = (s == 0 || s == 4 || s >= 12);
			e = ext ? 8'h80 : s >= 8 ? 8'h01 : s < 4 ? 8'h80 >> s : 8'h80 >> (s - 1);
			// 13 lies in the floating code range
			for (int c = 3; c < 16; c += 10) begin
				apb(1'b1, asq_pkg::OFFSET_CTRL0, 32'(c));
				`CHK("in", e, in_route)
				`CHK("conn", (ext && c < 12) ? 12'(1 << c) : 12'h0, ext_channel_connect)
			end
		end
	endtask : t_route
	task automatic t_ref();
		// bandgap enable sits outside; give it time before it is chosen
		repeat (50) @(posedge pclk);
		for (int v = 0; v < 32; v++) begin
			apb(1'b1, asq_pkg::OFFSET_CTRL2, {24'h0, 3'b100, 5'(v)});
			`CHK("ref", {1'b1, 2'(v), !v[4], v[4], v[3:2] == 0, v[3:2] == 1, v[3]}, ref_route)
		end
	endtask : t_ref
	task automatic t_pins();
		apb(1'b1, asq_pkg::OFFSET_PIN_FUNC, 32'h0a5);
		`CHK("dig", 12'hf5a, pin_digital_en)
		`CHK("pu", 12'hf5a, pin_pullup_en)
		`CHK("oe", 12'hf5a, pin_out_enable)
		@(posedge pclk);
		port_pullup_req <= 12'h0f0;
		port_out_enable_req <= 12'h00f;
		@(posedge pclk);
		@(negedge pclk);
		`CHK("pu2", 12'h050, pin_pullup_en)
		`CHK("oe2", 12'h00a, pin_out_enable)
	endtask : t_pins
	task automatic t_conv(input logic [2:0] div, input logic al, input logic [11:0] d);
		@(posedge pclk);
		adc_data_in <= d;
		apb(1'b1, asq_pkg::OFFSET_CTRL1, 32'(div));
		n_samp = 0;
		n_conv = 0;
		n_tick = 0;
		n_done = 0;
		// start pulse without power must be ignored
		apb(1'b1, asq_pkg::OFFSET_CTRL0, 32'h80);
		apb(1'b1, asq_pkg::OFFSET_CTRL0, 32'h00);
		apb(1'b1, asq_pkg::OFFSET_CTRL0, 32'ha0 | 32'(al) << 4);
		`CHK("armed", 0, n_samp)
		`CHK("pwr", 1'b1, conv_power)
		repeat (20) @(posedge pclk);
		apb(1'b1, asq_pkg::OFFSET_CTRL0, 32'h20 | 32'(al) << 4);
		apb(1'b0, asq_pkg::OFFSET_CTRL0, 32'h0);
		`CHK("busy", 1'b1, rd[6])
		for (int t = 0; t < 4000 && n_done == 0; t++) @(posedge pclk);
		@(negedge pclk);
		`CHK("samp", 4 << div, n_samp)
		`CHK("conv", 12 << div, n_conv)
		`CHK("tick", 16, n_tick)
		`CHK("done", 1, n_done)
		apb(1'b0, asq_pkg::OFFSET_CTRL0, 32'h0);
		`CHK("idle", 1'b0, rd[6])
		apb(1'b0, asq_pkg::OFFSET_RESULT_HI, 32'h0);
		`CHK("hi", {24'h0, al ? {4'h0, d[11:8]} : d[11:4]}, rd)
		apb(1'b0, asq_pkg::OFFSET_RESULT_LO, 32'h0);
		`CHK("lo", {24'h0, al ? d[7:0] : {d[3:0], 4'h0}}, rd)
		apb(1'b1, asq_pkg::OFFSET_CTRL0, 32'h0);
	endtask : t_conv
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_route();
		t_ref();
		t_pins();
		// divide by one is too fast for real use; run only to reach the bypass ratio
		t_conv(3'h0, 1'b0, 12'habc);
		t_conv(3'h5, 1'b1, 12'h5e3);
		close_out();
	end
	initial begin
		#400000;
		fail_count++;
		close_out();
	end
endmodule : adc_sequencing_and_input_select_bench

// file: testbench/asq_asserts.sv
// port checker for the converter sequencer
`timescale 1ns/1ns
module asq_checker #(
	parameter int NUM_CH = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_sample,
	input wire logic conv_convert,
	input wire logic conv_done,
	input wire asq_pkg::asq_ref_route_type ref_route,
	input wire asq_pkg::asq_in_route_type in_route,
	input wire logic [NUM_CH-1:0] ext_channel_connect,
	input wire logic [NUM_CH-1:0] pin_pullup_en,
	input wire logic [NUM_CH-1:0] pin_out_enable,
	input wire logic [NUM_CH-1:0] pin_digital_en
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_done_pulse; conv_done |=> !conv_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
	// done must close a conversion phase, never a sampling one
	property p_done_end;
		conv_done |-> !conv_sample && ($past(conv_convert) || $past(conv_convert, 2));
	endproperty
	a_done_end: assert property (p_done_end) else $error("done without conversion");
	property p_phase_excl; !(conv_sample && conv_convert); endproperty
	a_phase_excl: assert property (p_phase_excl) else $error("phases overlap");
	property p_sample_len; $rose(conv_sample) |-> conv_sample[*4]; endproperty
	a_sample_len: assert property (p_sample_len) else $error("sampling too short");
	property p_one_ch; $onehot0(ext_channel_connect); endproperty
	a_one_ch: assert property (p_one_ch) else $error("several channels connected");
	property p_isolate; !in_route.ext_path |-> ext_channel_connect == '0; endproperty
	a_isolate: assert property (p_isolate) else $error("channel left on");
	property p_in_hot; $onehot0(in_route); endproperty
	a_in_hot: assert property (p_in_hot) else $error("input route not one-hot");
	property p_ref_hot;
		$onehot0({ref_route.ref_supply, ref_route.ref_ext_pin, ref_route.ref_amp});
	endproperty
	a_ref_hot: assert property (p_ref_hot) else $error("reference pin not cut off");
	property p_amp_in; !(ref_route.amp_from_pin && ref_route.amp_from_bandgap); endproperty
	a_amp_in: assert property (p_amp_in) else $error("amp fed twice");
	property p_pull; (pin_pullup_en & ~pin_digital_en) == '0; endproperty
	a_pull: assert property (p_pull) else $error("pull-high on analog pin");
	property p_dir; (pin_out_enable & ~pin_digital_en) == '0; endproperty
	a_dir: assert property (p_dir) else $error("driver on analog pin");
	c_done: cover property (conv_done);
	c_ground: cover property (in_route.ground);
	c_err: cover property (pslverr && pready);
endmodule : asq_checker
bind asq_top asq_checker #(.NUM_CH(NUM_CH)) chk_u (.pclk(pclk), .presetn(presetn),
	.pready(pready), .pslverr(pslverr), .conv_sample(conv_sample),
	.conv_convert(conv_convert), .conv_done(conv_done), .ref_route(ref_route),
	.in_route(in_route), .ext_channel_connect(ext_channel_connect),
	.pin_pullup_en(pin_pullup_en), .pin_out_enable(pin_out_enable),
	.pin_digital_en(pin_digital_en));
